// file: fvltc_pkg.sv
// Constants, register map and output carrier of the flash trigger block.
package fvltc_pkg;

    // Register byte offsets.
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_LEVEL  = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;

    // Control register fields.
    localparam int CTRL_MODE_LSB  = 0;
    localparam int CTRL_FVM_BIT   = 2;
    localparam int CTRL_TTS_BIT   = 3;
    localparam int CTRL_SFT_BIT   = 4;
    localparam int CTRL_FLASH_TIME_SEL_LSB  = 5;
    localparam int CTRL_RANGE_BIT = 8;

    // Level register fields.
    localparam int LVL_OV_LSB  = 0;
    localparam int LVL_DC_LSB  = 4;
    localparam int LVL_EN_LSB  = 8;

    // Status register fields.
    localparam int STA_TO_BIT    = 0;
    localparam int STA_WDX_BIT   = 1;
    localparam int STA_FLASH_BIT = 2;
    localparam int STA_VIDEO_BIT = 3;
    localparam int STA_STRB_LSB  = 4;

    // Reset values.
    localparam logic [1:0] MODE_RST   = 2'h0;
    localparam logic [3:0] OV_RST     = 4'h0;
    localparam logic [2:0] DC_RST     = 3'h0;
    localparam logic [2:0] LEDEN_RST  = 3'h7;
    localparam logic [2:0] FLASH_TIME_SEL_RST   = 3'h0;

    // Operating modes of the two-bit mode field.
    localparam logic [1:0] MODE_OFF   = 2'h0;
    localparam logic [1:0] MODE_VIDEO = 2'h1;
    localparam logic [1:0] MODE_FLASH = 2'h2;
    localparam logic [1:0] MODE_VOLT  = 2'h3;

    // Output voltage span, 3825 mV to 5700 mV in 125 mV steps.
    localparam int VOUT_MIN_MV  = 3825;
    localparam int VOUT_STEP_MV = 125;

    // Timing: clock rate, watchdog time and flash timer step.
    localparam int unsigned CLK_HZ        = 25000000;
    localparam int unsigned WD_TIME_MS    = 13000;
    localparam int unsigned WD_CYC        = WD_TIME_MS * (CLK_HZ / 1000);
    localparam int unsigned FLASH_STEP_US = 25000;
    localparam int unsigned FLASH_STEP_CYC =
        FLASH_STEP_US * (CLK_HZ / 1000000);
    localparam int FLASH_RANGE_SHIFT = 3;

    // Commands to the analog side, one registered bundle.
    typedef struct packed {
        logic       converterOn;
        logic       voltageRegulationMode;
        logic       flashLevel;
        logic       videoLevel;
        logic [2:0] ledSinksOneToThree;
        logic [3:0] outputVoltageSel;
        logic [2:0] videoCurrentSel;
    } fvltc_cmd_t;

    // Flash timer states.
    typedef enum logic {FL_IDLE, FL_ON} fvltc_flash_t;

endpackage

// file: fvltc_ctrl.sv
// Mode control, strobe triggering and safety timers with an APB register port.
//
// Implementation choices: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps

module fvltc_ctrl #(
    parameter int unsigned WD_CYCLES   = fvltc_pkg::WD_CYC,
    parameter int unsigned FLASH_STEP  = fvltc_pkg::FLASH_STEP_CYC
) (
    input  wire logic              ref_clk,
    input  wire logic              rst_n,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              strobe_trigger_in,
    input  wire logic              strobe_select_in,
    output fvltc_pkg::fvltc_cmd_t  ledCmd
);

    // Register state.
    logic [1:0]  mode_q;
    logic        forceVoltageMode_q;
    logic        triggerTypeSel_q;
    logic        startFlashBit_q;
    logic [2:0]  flashTimeSel_q;
    logic        flashTimeRangeSel_q;
    logic [3:0]  outputVoltageSel_q;
    logic [2:0]  videoCurrentSel_q;
    logic [2:0]  ledEnable_q;
    logic        timeoutFlag_q;
    logic        wdExpiredFlag_q;
    logic [31:0] prdata_q;

    // Strobe synchronisers and edge memory.
    logic [1:0]  strbMeta_q;
    logic [1:0]  strbSync_q;
    logic        trigPrev_q;
    logic        trigSync;
    logic        selSync;
    logic        trigRise;

    // Timers.
    fvltc_pkg::fvltc_flash_t flashState_q;
    logic        flashFixed_q;
    logic [31:0] flashCnt_q;
    logic [31:0] flashDur;
    logic [31:0] wdCnt_q;
    logic        wdRun;
    logic        wdExpire;
    logic        flashTimeout;

    // Bus strobes and decoded events.
    logic        wrAccess;
    logic        ctrlWrite;
    logic        levelWrite;
    logic        statusWrite;
    logic        sftRise;
    logic        flashMode;
    logic        flashOn;
    logic        videoOn;
    logic        startFixed;
    logic        startLevel;
    fvltc_pkg::fvltc_cmd_t cmd_d;
    fvltc_pkg::fvltc_cmd_t cmd_q;

    // Address decode shared by reads and writes.
    function automatic logic addrMapped(input logic [7:0] a);
        addrMapped = (a == fvltc_pkg::REG_CTRL) ||
                     (a == fvltc_pkg::REG_LEVEL) ||
                     (a == fvltc_pkg::REG_STATUS);
    endfunction

    // The slave answers in the first access cycle.
    assign pready   = 1'b1;
    assign pslverr  = psel && penable && !addrMapped(paddr);
    assign prdata   = prdata_q;
    assign wrAccess = psel && penable && pwrite;
    assign ctrlWrite   = wrAccess && (paddr == fvltc_pkg::REG_CTRL);
    assign levelWrite  = wrAccess && (paddr == fvltc_pkg::REG_LEVEL);
    assign statusWrite = wrAccess && (paddr == fvltc_pkg::REG_STATUS);

    // two-stage synchronisers
    // Both strobe pins pass two flip-flops before any logic sees them.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            strbMeta_q <= 2'h0;
            strbSync_q <= 2'h0;
            trigPrev_q <= 1'b0;
        end
        else
        begin
            strbMeta_q <= {strobe_select_in, strobe_trigger_in};
            strbSync_q <= strbMeta_q;
            trigPrev_q <= strbSync_q[0];
        end
    end

    assign trigSync = strbSync_q[0];
    assign selSync  = strbSync_q[1];
    assign trigRise = trigSync && !trigPrev_q;

    // flash duration select
    // Step count times code plus one, stretched by the range bit.
    assign flashDur = (32'(flashTimeSel_q) + 32'h1) * FLASH_STEP
                      << (flashTimeRangeSel_q ? fvltc_pkg::FLASH_RANGE_SHIFT
                                              : 0);

    assign flashMode = (mode_q == fvltc_pkg::MODE_FLASH);
    assign sftRise   = ctrlWrite && pwdata[fvltc_pkg::CTRL_SFT_BIT]
                       && !startFlashBit_q;

    // trigger acts only while flash is selected
    assign startFixed = flashMode && !selSync &&
                        ((trigRise && triggerTypeSel_q) || sftRise);
    assign startLevel = flashMode && !selSync && trigRise &&
                        !triggerTypeSel_q;
    assign flashTimeout = (flashState_q == fvltc_pkg::FL_ON) && flashMode
                          && (flashCnt_q == flashDur - 32'h1);

    // Control register, with watchdog and timeout side effects.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            mode_q              <= fvltc_pkg::MODE_RST;
            forceVoltageMode_q  <= 1'b0;
            triggerTypeSel_q    <= 1'b0;
            startFlashBit_q     <= 1'b0;
            flashTimeSel_q      <= fvltc_pkg::FLASH_TIME_SEL_RST;
            flashTimeRangeSel_q <= 1'b0;
        end
        else if (ctrlWrite)
        begin
            mode_q <= pwdata[fvltc_pkg::CTRL_MODE_LSB +: 2];
            forceVoltageMode_q  <= pwdata[fvltc_pkg::CTRL_FVM_BIT];
            triggerTypeSel_q    <= pwdata[fvltc_pkg::CTRL_TTS_BIT];
            startFlashBit_q     <= pwdata[fvltc_pkg::CTRL_SFT_BIT];
            flashTimeSel_q      <= pwdata[fvltc_pkg::CTRL_FLASH_TIME_SEL_LSB +: 3];
            flashTimeRangeSel_q <= pwdata[fvltc_pkg::CTRL_RANGE_BIT];
        end
        else
        begin
            if (wdExpire)
            begin
                mode_q <= fvltc_pkg::MODE_OFF;
            end
            if (flashTimeout)
            begin
                startFlashBit_q <= 1'b0;
            end
        end
    end

    // Level register: output voltage, video current and sink enables.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            outputVoltageSel_q <= fvltc_pkg::OV_RST;
            videoCurrentSel_q  <= fvltc_pkg::DC_RST;
            ledEnable_q        <= fvltc_pkg::LEDEN_RST;
        end
        else if (levelWrite)
        begin
            outputVoltageSel_q <= pwdata[fvltc_pkg::LVL_OV_LSB +: 4];
            videoCurrentSel_q  <= pwdata[fvltc_pkg::LVL_DC_LSB +: 3];
            ledEnable_q        <= pwdata[fvltc_pkg::LVL_EN_LSB +: 3];
        end
    end

    // Sticky flags; a new event wins over a write-one clear.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            timeoutFlag_q   <= 1'b0;
            wdExpiredFlag_q <= 1'b0;
        end
        else
        begin
            if (flashTimeout)
                timeoutFlag_q <= 1'b1;
            else if (statusWrite && pwdata[fvltc_pkg::STA_TO_BIT])
                timeoutFlag_q <= 1'b0;
            if (wdExpire)
                wdExpiredFlag_q <= 1'b1;
            else if (statusWrite && pwdata[fvltc_pkg::STA_WDX_BIT])
                wdExpiredFlag_q <= 1'b0;
        end
    end

    // Read data is captured in the setup cycle and shown in the access.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            prdata_q <= 32'h0;
        end
        else if (psel && !penable && !pwrite)
        begin
            prdata_q <= 32'h0;
            if (paddr == fvltc_pkg::REG_CTRL)
            begin
                prdata_q[fvltc_pkg::CTRL_MODE_LSB +: 2] <= mode_q;
                prdata_q[fvltc_pkg::CTRL_FVM_BIT]  <= forceVoltageMode_q;
                prdata_q[fvltc_pkg::CTRL_TTS_BIT]  <= triggerTypeSel_q;
                prdata_q[fvltc_pkg::CTRL_SFT_BIT]  <= startFlashBit_q;
                prdata_q[fvltc_pkg::CTRL_FLASH_TIME_SEL_LSB +: 3] <= flashTimeSel_q;
                prdata_q[fvltc_pkg::CTRL_RANGE_BIT] <= flashTimeRangeSel_q;
            end
            else if (paddr == fvltc_pkg::REG_LEVEL)
            begin
                prdata_q[fvltc_pkg::LVL_OV_LSB +: 4] <= outputVoltageSel_q;
                prdata_q[fvltc_pkg::LVL_DC_LSB +: 3] <= videoCurrentSel_q;
                prdata_q[fvltc_pkg::LVL_EN_LSB +: 3] <= ledEnable_q;
            end
            else if (paddr == fvltc_pkg::REG_STATUS)
            begin
                prdata_q[fvltc_pkg::STA_TO_BIT]    <= timeoutFlag_q;
                prdata_q[fvltc_pkg::STA_WDX_BIT]   <= wdExpiredFlag_q;
                prdata_q[fvltc_pkg::STA_FLASH_BIT] <= flashOn;
                prdata_q[fvltc_pkg::STA_VIDEO_BIT] <= videoOn;
                prdata_q[fvltc_pkg::STA_STRB_LSB +: 2] <= strbSync_q;
            end
        end
    end

    assign wdRun    = (mode_q == fvltc_pkg::MODE_VIDEO) && !selSync;
    // a mode write restarts the count
    assign wdExpire = wdRun && !ctrlWrite &&
                      (wdCnt_q == WD_CYCLES - 32'h1);

    // Video light watchdog counter.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            wdCnt_q <= 32'h0;
        else if (!wdRun || ctrlWrite || wdExpire)
            wdCnt_q <= 32'h0;
        else
            wdCnt_q <= wdCnt_q + 32'h1;
    end

    // Flash safety timer: fixed duration or level bounded.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            flashState_q <= fvltc_pkg::FL_IDLE;
            flashFixed_q <= 1'b0;
            flashCnt_q   <= 32'h0;
        end
        else
        begin
            case (flashState_q)
                fvltc_pkg::FL_IDLE:
                begin
                    flashCnt_q <= 32'h0;
                    if (startFixed)
                    begin
                        flashState_q <= fvltc_pkg::FL_ON;
                        flashFixed_q <= 1'b1;
                    end
                    else if (startLevel)
                    begin
                        flashState_q <= fvltc_pkg::FL_ON;
                        flashFixed_q <= 1'b0;
                    end
                end
                fvltc_pkg::FL_ON:
                begin
                    flashCnt_q <= flashCnt_q + 32'h1;
                    if (!flashMode)
                        flashState_q <= fvltc_pkg::FL_IDLE;
                    // level flash forced off at limit
                    else if (flashTimeout)
                        flashState_q <= fvltc_pkg::FL_IDLE;
                    // level flash stops on trigger low or select high
                    else if (!flashFixed_q && (!trigSync || selSync))
                        flashState_q <= fvltc_pkg::FL_IDLE;
                end
                default:
                    flashState_q <= fvltc_pkg::FL_IDLE;
            endcase
        end
    end

    assign flashOn = flashMode && (flashState_q == fvltc_pkg::FL_ON);
    // select high with trigger gives video
    // mode 01 holds video light regardless
    assign videoOn = (mode_q == fvltc_pkg::MODE_VIDEO) ||
                     (flashMode && selSync && trigSync);

    // Commands to the converter and current sinks.
    always_comb
    begin
        cmd_d = '0;
        cmd_d.outputVoltageSel = outputVoltageSel_q;
        cmd_d.videoCurrentSel  = videoCurrentSel_q;
        // converter off only in unforced mode 00
        cmd_d.converterOn = (mode_q != fvltc_pkg::MODE_OFF) ||
                            forceVoltageMode_q;
        cmd_d.voltageRegulationMode =
            (mode_q == fvltc_pkg::MODE_VOLT) || forceVoltageMode_q;
        if (mode_q != fvltc_pkg::MODE_VOLT)
        begin
            cmd_d.flashLevel = flashOn;
            cmd_d.videoLevel = videoOn && !flashOn;
            cmd_d.ledSinksOneToThree =
                ledEnable_q & {3{flashOn || videoOn}};
        end
    end

    // Output command bundle register.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            cmd_q <= '0;
        else
            cmd_q <= cmd_d;
    end

    assign ledCmd = cmd_q;

    default clocking cbMain @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    // Steps of an edge-fired flash: armed idle and a rising edge in the same cycle.
    sequence seqEdgeArm;
        flashState_q == fvltc_pkg::FL_IDLE && flashMode &&
        triggerTypeSel_q && !selSync;
    endsequence
    sequence seqEdgeFire;
        seqEdgeArm ##0 trigRise;
    endsequence

    chk_video_no_flash: assert property (
        mode_q == fvltc_pkg::MODE_VIDEO |-> ##1 !cmd_q.flashLevel)
        else $error("flash driven in video mode");

    chk_wd_expiry: assert property (
        wdExpire |=> mode_q == fvltc_pkg::MODE_OFF && wdExpiredFlag_q)
        else $error("watchdog expiry did not shut down");

    chk_wd_held_sel: assert property (
        selSync |=> wdCnt_q == 32'h0)
        else $error("watchdog counted with select high");

    chk_edge_start: assert property (
        seqEdgeFire |=> flashOn ##1 cmd_q.flashLevel)
        else $error("edge trigger did not start flash");

    chk_edge_holds: assert property (
        flashOn && flashFixed_q && !flashTimeout |=> flashOn)
        else $error("fixed flash ended before timeout");

    // fixed flash ends at timer end
    chk_flash_bound: assert property (
        flashTimeout |=> !flashOn && timeoutFlag_q)
        else $error("flash ran past its timer");

    chk_sft_clear: assert property (
        flashTimeout && !ctrlWrite |=> !startFlashBit_q)
        else $error("start bit survived timeout");

    // level flash stops on trigger low
    chk_level_stop: assert property (
        flashOn && !flashFixed_q && !trigSync |=> !flashOn)
        else $error("level flash kept after trigger low");

    chk_volt_sinks_off: assert property (
        mode_q == fvltc_pkg::MODE_VOLT |=>
            cmd_q.ledSinksOneToThree == 3'h0 &&
            cmd_q.voltageRegulationMode)
        else $error("sinks on in voltage mode");

    chk_shutdown: assert property (
        mode_q == fvltc_pkg::MODE_OFF && !forceVoltageMode_q |=>
            !cmd_q.converterOn && cmd_q.ledSinksOneToThree == 3'h0)
        else $error("converter active in shutdown");

endmodule // fvltc_ctrl

// file: fvltc_cam_model.sv
// Camera module model that drives the two strobe pins of the block.
`timescale 1ns/100ps

module fvltc_cam_model (
    input  wire logic ref_clk,
    output logic      strobe_trigger_in,
    output logic      strobe_select_in
);
    // Both strobes rest low, which selects flash and no trigger.
    initial
    begin
        strobe_trigger_in = 1'b0;
        strobe_select_in  = 1'b0;
    end

    task automatic sel(input logic v);
        @(posedge ref_clk);
        strobe_select_in <= v;
    endtask

    // Raises the trigger for the given number of clock cycles.
    task automatic pulse(input int w);
        @(posedge ref_clk);
        strobe_trigger_in <= 1'b1;
        repeat (w) @(posedge ref_clk);
        strobe_trigger_in <= 1'b0;
    endtask
endmodule // fvltc_cam_model

// file: testbench.sv
// Self-checking testbench of the flash trigger block.
`timescale 1ns/100ps

module testbench;
    localparam int WD = 200;
    localparam int FS = 4;
    logic                  ref_clk;
    logic                  rst_n;
    logic                  psel;
    logic                  penable;
    logic                  pwrite;
    logic [7:0]            paddr;
    logic [31:0]           pwdata;
    logic [31:0]           prdata;
    logic [31:0]           rd;
    logic                  pready;
    logic                  pslverr;
    logic                  err;
    logic                  trig;
    logic                  sel;
    fvltc_pkg::fvltc_cmd_t ledCmd;
    int                    nFail;
    int                    testsRun;
    int                    len;

    // Clock of 40 ns period and inputs quiet at time zero.
    initial
    begin
        ref_clk = 1'b0;
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        nFail = 0;
        testsRun = 0;
    end
    always #20 ref_clk = ~ref_clk;

    fvltc_ctrl #(.WD_CYCLES(WD), .FLASH_STEP(FS)) dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .strobe_trigger_in(trig),
        .strobe_select_in(sel), .ledCmd(ledCmd));

    fvltc_cam_model cam (
        .ref_clk(ref_clk), .strobe_trigger_in(trig),
        .strobe_select_in(sel));

    // Prints the counts and the verdict, then stops the run.
    task automatic results;
        $display("Checks %0d, mismatches %0d", testsRun, nFail);
        if (nFail == 0 && testsRun > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Compares one value and counts the outcome.
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        testsRun++;
        if (got !== exp)
        begin
            nFail++;
            $display("wrong value at %0t: got %h, expected %h",
                $time, got, exp);
        end
    endtask

    // One APB transfer: setup, then access until pready is sampled high.
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        // A slave that never answers counts as a mismatch.
        if (n >= 50)
            nFail++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Reads a register and compares the masked word.
    task automatic rdc(input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        cmp(rd & m, exp);
    endtask

    // Counts the cycles for which the flash level stands high.
    task automatic meas(output int n);
        int w;
        n = 0;
        w = 0;
        while (ledCmd.flashLevel !== 1'b1 && w < 40)
        begin
            @(negedge ref_clk);
            w++;
        end
        while (ledCmd.flashLevel === 1'b1 && n < 400)
        begin
            @(negedge ref_clk);
            n++;
        end
    endtask

    // Register reset values and an unmapped address.
    task automatic t_reset;
        rdc(fvltc_pkg::REG_CTRL, 32'hFFFFFFFF, 32'h0);
        rdc(fvltc_pkg::REG_LEVEL, 32'hFFFFFFFF, 32'h700);
        apb(1'b0, 8'h0C, 32'h0);
        cmp(32'(err), 32'h1);
        cmp(rd, 32'h0);
        cmp(32'(pready), 32'h1);
    endtask

    // Every mode with and without forced voltage regulation.
    task automatic t_modes;
        apb(1'b1, fvltc_pkg::REG_LEVEL, 32'h75F);
        for (int m = 0; m < 4; m++)
        begin
            for (int f = 0; f < 2; f++)
            begin
                apb(1'b1, fvltc_pkg::REG_CTRL, 32'(f * 4 + m));
                repeat (5) @(negedge ref_clk);
                len = 32'(m == 3 || f == 1);
                cmp(32'(ledCmd.voltageRegulationMode), len);
                cmp(32'(ledCmd.videoLevel), 32'(m == 1));
                cmp(32'(ledCmd.outputVoltageSel), 32'hF);
                cmp(32'(ledCmd.videoCurrentSel), 32'h5);
                len = (m == 1) ? 7 : 0;
                cmp(32'(ledCmd.ledSinksOneToThree), len);
                if (m == 0)
                    cmp(32'(ledCmd.converterOn), 32'(f));
                if (m == 3)
                    cmp(32'(ledCmd.ledSinksOneToThree), 32'h0);
            end
        end
    endtask

    // Video mode ignores the trigger; its watchdog needs a refresh unless select is held high.
    task automatic t_video;
        apb(1'b1, fvltc_pkg::REG_CTRL, 32'h1);
        fork
            cam.pulse(3);
            meas(len);
        join
        cmp(32'(len), 32'h0);
        apb(1'b1, fvltc_pkg::REG_CTRL, 32'h1);
        repeat (150) @(posedge ref_clk);
        apb(1'b1, fvltc_pkg::REG_CTRL, 32'h1);
        repeat (150) @(posedge ref_clk);
        rdc(fvltc_pkg::REG_STATUS, 32'hA, 32'h8);
        repeat (100) @(posedge ref_clk);
        rdc(fvltc_pkg::REG_STATUS, 32'hA, 32'h2);
        rdc(fvltc_pkg::REG_CTRL, 32'h3, 32'h0);
        apb(1'b1, fvltc_pkg::REG_STATUS, 32'h3);
        cam.sel(1'b1);
        apb(1'b1, fvltc_pkg::REG_CTRL, 32'h1);
        repeat (300) @(posedge ref_clk);
        rdc(fvltc_pkg::REG_STATUS, 32'h3A, 32'h28);
        cam.sel(1'b0);
        apb(1'b1, fvltc_pkg::REG_CTRL, 32'h0);
    endtask

    // Edge, level and start-bit flashes with their timer lengths.
    task automatic t_flash;
        apb(1'b1, fvltc_pkg::REG_CTRL, 32'h6A);
        fork
            meas(len);
            begin
                cam.pulse(2);
                repeat (6) @(posedge ref_clk);
                cam.pulse(2);
            end
        join
        cmp(32'(len), 32'(4 * FS));
        rdc(fvltc_pkg::REG_STATUS, 32'h1, 32'h1);
        apb(1'b1, fvltc_pkg::REG_STATUS, 32'h1);
        apb(1'b1, fvltc_pkg::REG_CTRL, 32'h22);
        fork
            cam.pulse(4);
            meas(len);
        join
        cmp(32'(len), 32'h4);
        fork
            cam.pulse(20);
            meas(len);
        join
        cmp(32'(len), 32'(2 * FS));
        apb(1'b1, fvltc_pkg::REG_CTRL, 32'h11A);
        meas(len);
        cmp(32'(len), 32'(8 * FS));
        rdc(fvltc_pkg::REG_CTRL, 32'hFFFFFFFF, 32'h10A);
        // Select high in flash mode turns the trigger into video light.
        cam.sel(1'b1);
        fork
            cam.pulse(8);
            begin
                repeat (6) @(negedge ref_clk);
                cmp(32'(ledCmd.videoLevel), 32'h1);
                cmp(32'(ledCmd.flashLevel), 32'h0);
            end
        join
        cam.sel(1'b0);
    endtask

    // A reset in mid-run brings back shutdown and reset values.
    task automatic t_rerun;
        @(posedge ref_clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(negedge ref_clk);
        cmp(32'(ledCmd), 32'h0);
        rdc(fvltc_pkg::REG_CTRL, 32'hFFFFFFFF, 32'h0);
        rdc(fvltc_pkg::REG_STATUS, 32'h3F, 32'h0);
    endtask

    // Main sequence after ten cycles of reset.
    initial
    begin
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_reset();
        t_modes();
        t_video();
        t_flash();
        t_rerun();
        results();
    end

    // Cuts a hang short well beyond the expected run length.
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        nFail++;
        results();
    end
endmodule // testbench
